// ### verif/ebwc_chk.sv
// port assertions for the wait control block
`timescale 1ns/10ps
module ebwc_chk(
  input wire I_CLK,
  input wire I_RESET_N,
  input wire [3:0] O_AREA_SELECT,
  input wire O_FLASH_SELECT,
  input wire O_EXT_DONE,
  input wire O_EXT_BUSY
);
  wire s = |O_AREA_SELECT;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  AST_WAIT: assert property ($rose(s) |-> ##[1:9] !s)
    else $error("strobe too long");
  AST_RECOV: assert property (O_EXT_DONE |-> ##[1:3] !O_EXT_BUSY)
    else $error("recovery too long");
  AST_DONE: assert property ($fell(s) |-> O_EXT_DONE)
    else $error("strobe ended without done");
  AST_AREA: assert property (s |-> $onehot(O_AREA_SELECT))
    else $error("two areas at once");
  AST_FLASH: assert property (O_FLASH_SELECT |-> !s ##1 !O_FLASH_SELECT)
    else $error("bad flash pulse");
  cover property ($fell(s));
  cover property (O_FLASH_SELECT);
  cover property ($fell(O_EXT_BUSY));
endmodule
bind ebwc_top ebwc_chk ebwc_chk_i(.I_CLK,.I_RESET_N,.O_AREA_SELECT,
  .O_FLASH_SELECT,.O_EXT_DONE,.O_EXT_BUSY);

// ### verif/ebwc_mem.sv
// far-side memory model, measures strobe length of each access
`timescale 1ns/10ps
module ebwc_mem(
  input wire i_clk,
  input wire [3:0] i_sel,
  output reg [3:0] o_len = 4'h0,
  output reg [3:0] o_hit = 4'h0
);
  reg [3:0] cnt = 4'h0;
  always @(posedge i_clk) begin
    cnt <= (|i_sel) ? cnt + 4'h1 : 4'h0;
    if (|i_sel) o_len <= cnt + 4'h1;
    if (|i_sel) o_hit <= i_sel;
  end
endmodule

// ### verif/tb.sv
// self-checking bench for the wait control block
`timescale 1ns/10ps
module tb;
  reg I_CLK=0,I_RESET_N=0,I_HSEL=0,I_HWRITE=0,I_EXT_REQ=0;
  reg [7:0] I_HADDR=8'h0;
  reg [2:0] I_HSIZE=3'h0;
  reg [1:0] I_HTRANS=2'h0,I_EXT_AREA=2'h0;
  reg [31:0] I_HWDATA=32'h0,r;
  reg [19:0] I_EXT_ADDR=20'h0;
  wire [31:0] O_HRDATA;
  wire O_HREADYOUT,O_HRESP,O_FLASH_SELECT,O_EXT_DONE,O_EXT_BUSY;
  wire [3:0] O_AREA_SELECT,len,hit;
  integer err_count=0,n_compared=0,cyc=0,i,k;
  always #4 I_CLK=~I_CLK;
  ebwc_top ebwc_top_i(.I_CLK,.I_RESET_N,.I_HSEL,.I_HADDR,.I_HTRANS,
    .I_HWRITE,.I_HSIZE,.I_HWDATA,.I_HREADY(O_HREADYOUT),.O_HRDATA,
    .O_HREADYOUT,.O_HRESP,.I_EXT_REQ,.I_EXT_AREA,.I_EXT_ADDR,
    .O_AREA_SELECT,.O_FLASH_SELECT,.O_EXT_DONE,.O_EXT_BUSY);
  ebwc_mem ebwc_mem_i(.i_clk(I_CLK),.i_sel(O_AREA_SELECT),.o_len(len),
    .o_hit(hit));
  task chk(input string n,input [31:0] g,e);
    n_compared=n_compared+1;
    if (g!==e) begin
      err_count=err_count+1;
      $display("BAD %s exp %h got %h",n,e,g);
    end
  endtask
  task test_done;
    $display("compared %0d bad %0d",n_compared,err_count);
    if (err_count==0 && n_compared>0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a clean run needs under two hundred cycles; this only guards a hang
  always @(posedge I_CLK) begin
    cyc=cyc+1;
    if (cyc==3000) begin
      err_count=err_count+1;
      test_done;
    end
  end
  // address phase held until hready, then data phase; read taken there
  task bus(input w,input [7:0] a,input [31:0] d);
    I_HSEL<=1;
    I_HTRANS<=2'h2;
    I_HADDR<=a;
    I_HWRITE<=w;
    I_HSIZE<=3'h2;
    do @(posedge I_CLK); while (O_HREADYOUT!==1'b1);
    I_HSEL<=0;
    I_HTRANS<=2'h0;
    I_HWDATA<=d;
    do @(posedge I_CLK); while (O_HREADYOUT!==1'b1);
    r=O_HRDATA;
    chk("hresp",O_HRESP,0);
  endtask
  // one-cycle request; released lines show the inverse, not the old value
  // outputs read at an edge hold what the edge before launched
  task acc(input [1:0] a,input [19:0] ad,input [3:0] w,input [3:0] rc);
    I_EXT_REQ<=1;
    I_EXT_AREA<=a;
    I_EXT_ADDR<=ad;
    @(posedge I_CLK);
    I_EXT_REQ<=0;
    I_EXT_AREA<=~a;
    I_EXT_ADDR<=~ad;
    do @(posedge I_CLK); while (O_EXT_DONE!==1'b1);
    chk("flash",O_FLASH_SELECT,w==15);
    if (w!=15) begin
      chk("waits",len,w+1);
      chk("area",hit,1<<a);
    end
    k=0;
    while (O_EXT_BUSY!==1'b0) begin
      @(posedge I_CLK);
      k=k+1;
    end
    chk("recovery",k,rc);
  endtask
  task t_regs;
    bus(0,8'h20,0);
    chk("selctl",r,32'h0F);
    bus(0,8'h30,0);
    chk("status",r,32'h0);
    bus(1,8'h24,32'h3);
    bus(0,8'h24,0);
    chk("recov",r,32'h3);
    bus(1,8'hFC,32'hFF);
    bus(0,8'hFC,0);
    chk("unmap",r,32'h0);
  endtask
  // walks expansion codes 00 to 10 once each and code 11 with every extended code once each, spread over the four areas (0 to 3, then 0 to 2)
  task t_wait;
    bus(1,8'h20,0);
    acc(2,0,0,3);
    bus(1,8'h20,32'hF);
    for (i=0;i<7;i=i+1) begin
      bus(1,8'h6C,(i<3?i:3)<<2*(i%4));
      bus(1,8'h44,(i<3?0:i-3)<<2*(i%4));
      bus(1,8'h24,i%4);
      acc(i%4,0,i<6?i+1:8,i%4);
    end
    bus(0,8'h44,0);
    chk("extwait",r,32'h30);
    bus(0,8'h6C,0);
    chk("waitexp",r,32'h30);
  endtask
  task t_flash;
    bus(1,8'h14,32'h8);
    bus(0,8'h14,0);
    chk("pmode",r,32'h8);
    acc(2,20'h0E000,15,0);
    acc(2,20'h0FFFF,15,0);
    acc(2,20'h0DFFF,8,2);
    acc(1,20'h0E000,1,2);
    bus(1,8'h14,0);
    acc(2,20'h0E000,8,2);
    bus(0,8'h30,0);
    chk("status",r,32'h2);
  endtask
  // a reset in mid-run must bring the settings back to their defaults
  task t_reset;
    I_RESET_N<=0;
    repeat (2) @(posedge I_CLK);
    I_RESET_N<=1;
    @(posedge I_CLK);
    bus(0,8'h24,0);
    chk("rst_recov",r,32'h0);
    bus(0,8'h20,0);
    chk("rst_selctl",r,32'h0F);
  endtask
  initial begin
    repeat (4) @(posedge I_CLK);
    I_RESET_N<=1;
    @(posedge I_CLK);
    t_regs;
    t_wait;
    t_flash;
    t_reset;
    test_done;
  end
endmodule

// ### verilog/ebwc_consts.vh
// constants for the external bus wait and recovery control block
// What this block does
// [R1] per area 0 to 8 access waits
// [R2] recovery of 0 to 3 cycles after access
// [R3] expansion code 11 uses area extended wait bits
// [R4] 0E000h-0FFFFh to area two or data flash
`ifndef EBWC_CONSTS_VH
`define EBWC_CONSTS_VH
// register indices, byte address is four times the index
`define EBWC_IDX_PROC_MODE 8'h05
`define EBWC_IDX_RECOVERY 8'h09
`define EBWC_IDX_EXT_WAIT 8'h11
`define EBWC_IDX_WAIT_EXP 8'h1B
`define EBWC_IDX_SEL_CTRL 8'h08
`define EBWC_IDX_STATUS 8'h0C
// field positions
`define EBWC_PM_AREA_SWITCH 3
// reset values
`define EBWC_RST_PROC_MODE 8'h00
`define EBWC_RST_RECOVERY 8'h00
`define EBWC_RST_EXT_WAIT 8'h00
`define EBWC_RST_WAIT_EXP 8'h00
`define EBWC_RST_SEL_CTRL 8'h0F
// wait counts for extended wait codes 00, 01, 10, 11
`define EBWC_EXT_WAIT_0 4'h4
`define EBWC_EXT_WAIT_1 4'h5
`define EBWC_EXT_WAIT_2 4'h6
`define EBWC_EXT_WAIT_3 4'h8
`define EBWC_EXP_DEFER 2'h3
// data flash window
`define EBWC_FLASH_LO 20'h0E000
`define EBWC_FLASH_HI 20'h0FFFF
`define EBWC_AREA_TWO 2'h2
`endif

// ### verilog/ebwc_top.v
// external bus wait-state, recovery and area decode control
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`include "ebwc_consts.vh"
module ebwc_top (
  input wire I_CLK,
  input wire I_RESET_N,
  input wire I_HSEL,
  input wire [7:0] I_HADDR,
  input wire [1:0] I_HTRANS,
  input wire I_HWRITE,
  input wire [2:0] I_HSIZE,
  input wire [31:0] I_HWDATA,
  input wire I_HREADY,
  output reg [31:0] O_HRDATA,
  output reg O_HREADYOUT,
  output reg O_HRESP,
  input wire I_EXT_REQ,
  input wire [1:0] I_EXT_AREA,
  input wire [19:0] I_EXT_ADDR,
  output reg [3:0] O_AREA_SELECT,
  output reg O_FLASH_SELECT,
  output reg O_EXT_DONE,
  output reg O_EXT_BUSY
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ACCESS = 2'h1;
  localparam ST_RECOVER = 2'h2;

  reg [7:0] processor_mode_one;
  reg [7:0] bus_recovery_cycles;
  reg [7:0] extended_area_wait;
  reg [7:0] area_wait_expansion;
  reg [7:0] area_select_control_reg;
  reg [1:0] state;
  reg [3:0] count;
  reg [1:0] cur_area;
  reg wr_pend;
  reg [5:0] wr_idx;
  reg [7:0] next_processor_mode_one;
  reg [7:0] next_bus_recovery_cycles;
  reg [7:0] next_extended_area_wait;
  reg [7:0] next_area_wait_expansion;
  reg [7:0] next_area_select_control_reg;
  reg [7:0] rd_val;
  wire [15:0] wait_flat;
  wire [3:0] sel_wait;
  wire addr_phase;
  wire in_flash;
  wire area_two_req;
  wire flash_window;
  wire [7:0] status_val;

  assign addr_phase = I_HSEL & I_HTRANS[1] & I_HREADY;

  // one wait figure per area
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_area
      wire [1:0] exp_code;
      wire [1:0] ext_code;
      reg [3:0] w;
      assign exp_code = area_wait_expansion[2*gi+1:2*gi];
      assign ext_code = extended_area_wait[2*gi+1:2*gi];
      always @* begin
        // basic bit clear means no waits, whatever the other fields say
        if (!area_select_control_reg[gi]) begin
          w = 4'h0; // R1
        end else if (exp_code == `EBWC_EXP_DEFER) begin
          case (ext_code) // R3
            2'h0: w = `EBWC_EXT_WAIT_0;
            2'h1: w = `EBWC_EXT_WAIT_1;
            2'h2: w = `EBWC_EXT_WAIT_2;
            default: w = `EBWC_EXT_WAIT_3;
          endcase
        end else begin
          w = {2'h0, exp_code} + 4'h1; // R1
        end
      end
      assign wait_flat[4*gi+3:4*gi] = w;
    end
  endgenerate

  assign sel_wait = wait_flat[4*I_EXT_AREA +: 4];
  // only area two gives up its top window; other areas never see flash
  assign area_two_req = I_EXT_AREA == `EBWC_AREA_TWO;
  assign flash_window = I_EXT_ADDR >= `EBWC_FLASH_LO &&
    I_EXT_ADDR <= `EBWC_FLASH_HI;
  assign in_flash = processor_mode_one[`EBWC_PM_AREA_SWITCH] &&
    area_two_req && flash_window; // R4
  assign status_val = {3'h0, O_EXT_BUSY, state, cur_area};

  // write data lands in the data phase; reads see it at once
  always @* begin
    next_processor_mode_one = processor_mode_one;
    next_bus_recovery_cycles = bus_recovery_cycles;
    next_extended_area_wait = extended_area_wait;
    next_area_wait_expansion = area_wait_expansion;
    next_area_select_control_reg = area_select_control_reg;
    if (wr_pend) begin
      case ({2'h0, wr_idx})
        `EBWC_IDX_PROC_MODE: next_processor_mode_one = I_HWDATA[7:0];
        `EBWC_IDX_RECOVERY: next_bus_recovery_cycles = I_HWDATA[7:0];
        `EBWC_IDX_EXT_WAIT: next_extended_area_wait = I_HWDATA[7:0];
        `EBWC_IDX_WAIT_EXP: next_area_wait_expansion = I_HWDATA[7:0];
        `EBWC_IDX_SEL_CTRL: next_area_select_control_reg = I_HWDATA[7:0];
        default: next_processor_mode_one = processor_mode_one;
      endcase
    end
  end

  always @* begin
    case ({2'h0, I_HADDR[7:2]})
      `EBWC_IDX_PROC_MODE: rd_val = next_processor_mode_one;
      `EBWC_IDX_RECOVERY: rd_val = next_bus_recovery_cycles;
      `EBWC_IDX_EXT_WAIT: rd_val = next_extended_area_wait;
      `EBWC_IDX_WAIT_EXP: rd_val = next_area_wait_expansion;
      `EBWC_IDX_SEL_CTRL: rd_val = next_area_select_control_reg;
      `EBWC_IDX_STATUS: rd_val = status_val;
      default: rd_val = 8'h00;
    endcase
  end

  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      processor_mode_one <= `EBWC_RST_PROC_MODE;
      bus_recovery_cycles <= `EBWC_RST_RECOVERY;
      extended_area_wait <= `EBWC_RST_EXT_WAIT;
      area_wait_expansion <= `EBWC_RST_WAIT_EXP;
      area_select_control_reg <= `EBWC_RST_SEL_CTRL;
      wr_pend <= 1'b0;
      wr_idx <= 6'h00;
    end else begin
      processor_mode_one <= next_processor_mode_one;
      bus_recovery_cycles <= next_bus_recovery_cycles;
      extended_area_wait <= next_extended_area_wait;
      area_wait_expansion <= next_area_wait_expansion;
      area_select_control_reg <= next_area_select_control_reg;
      wr_pend <= addr_phase & I_HWRITE;
      if (addr_phase) begin
        wr_idx <= I_HADDR[7:2];
      end
    end
  end

  // bus answer side: zero wait and always okay, so no error path exists
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_HRDATA <= 32'h00000000;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
      // read data registered in the address phase, stands until next read
      if (addr_phase && !I_HWRITE) begin
        O_HRDATA <= {24'h000000, rd_val};
      end
    end
  end

  // access sequencer
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= ST_IDLE;
      count <= 4'h0;
      cur_area <= 2'h0;
      O_AREA_SELECT <= 4'h0;
      O_FLASH_SELECT <= 1'b0;
      O_EXT_DONE <= 1'b0;
      O_EXT_BUSY <= 1'b0;
    end else begin
      O_EXT_DONE <= 1'b0;
      O_FLASH_SELECT <= 1'b0;
      case (state)
        ST_IDLE: begin
          // requests are only looked at here, so busy ones are dropped
          if (I_EXT_REQ) begin
            cur_area <= I_EXT_AREA;
            if (in_flash) begin
              // internal flash: no external strobe, no waits
              O_FLASH_SELECT <= 1'b1; // R4
              O_EXT_DONE <= 1'b1;
            end else begin
              O_AREA_SELECT <= 4'h1 << I_EXT_AREA;
              count <= sel_wait; // R1
              O_EXT_BUSY <= 1'b1;
              state <= ST_ACCESS;
            end
          end
        end
        ST_ACCESS: begin
          if (count == 4'h0) begin
            O_AREA_SELECT <= 4'h0;
            O_EXT_DONE <= 1'b1;
            count <= {2'h0, bus_recovery_cycles[1:0]}; // R2
            if (bus_recovery_cycles[1:0] == 2'h0) begin
              O_EXT_BUSY <= 1'b0;
              state <= ST_IDLE;
            end else begin
              state <= ST_RECOVER;
            end
          end else begin
            count <= count - 4'h1; // R1
          end
        end
        ST_RECOVER: begin
          // done cycle is the first recovery cycle, busy leaves as count hits 1
          if (count == 4'h1) begin
            O_EXT_BUSY <= 1'b0; // R2
            state <= ST_IDLE;
          end
          count <= count - 4'h1;
        end
        default: begin
          state <= ST_IDLE;
          O_EXT_BUSY <= 1'b0;
          O_AREA_SELECT <= 4'h0;
        end
      endcase
    end
  end
endmodule
